// ---- hdl/option_slot_pkg.sv ----
package option_slot_pkg;
  // Image geometry: 8 bytes, one bit per slot
  localparam int IMAGE_BYTES = 8;
  localparam int SLOT_BITS = 64;
  localparam int SLOT_IDX_W = 6;
  localparam int COUNT_W = 8;
  // Control and feedback bit 0 is the validity / active flag
  localparam int VALID_BIT = 0;
  // Highest slot number the diagnostics can hold
  localparam logic [COUNT_W-1:0] MAX_REPORTED = 8'h3F;
  // Fault code for a record aimed at an absent slot
  localparam logic [15:0] FAULT_ABSENT_SLOT = 16'h80B0;
  localparam logic [15:0] FAULT_NONE = 16'h0000;
  // Diagnostic status byte 1 bit for external diagnosis
  localparam int STATUS1_EXT_BIT = 3;
  localparam logic [7:0] STATUS1_RESET = 8'h00;
  localparam logic [SLOT_BITS-1:0] MAP_RESET = 64'h0000_0000_0000_0000;
endpackage

// ---- hdl/option_slot_presence_control.sv ----
`timescale 1ns/10ps
module option_slot_presence_control
  import option_slot_pkg::*;
#(
  parameter int DATA_W = 32 // Station process data width
) (
  input wire logic clk, // Station clock, 125 MHz
  input wire logic reset, // Synchronous reset, active high
  input wire logic cfg_accepted, // Configuration data accepted pulse
  input wire logic cycle_strobe, // One exchange cycle pulse
  input wire logic ctrl_wr, // Control image write pulse
  input wire logic [SLOT_BITS-1:0] ctrl_image, // Control image, byte k in bits 8k+7..8k
  input wire logic [DATA_W-1:0] output_process_image, // Other output bytes from master
  input wire logic [DATA_W-1:0] station_inputs, // Input data from modules
  input wire logic [SLOT_BITS-1:0] slot_configured, // Designed configuration per slot
  input wire logic [SLOT_BITS-1:0] slot_plugged, // Module physically present per slot
  input wire logic [SLOT_BITS-1:0] slot_good, // Right module with good status
  input wire logic [COUNT_W-1:0] plugged_count, // Plugged modules as the station counts them
  input wire logic allow_mismatch, // Operation with set/actual mismatch allowed
  input wire logic nv_valid_in, // Retained option information valid
  input wire logic [SLOT_BITS-1:0] nv_map_in, // Retained slot presence map
  input wire logic ds_req, // Data record request pulse
  input wire logic [SLOT_IDX_W-1:0] ds_slot, // Configured slot number of request
  output logic [DATA_W-1:0] station_outputs, // Output data to modules
  output logic [DATA_W-1:0] input_process_image, // Input data to master
  output logic [SLOT_BITS-1:0] slot_presence_feedback, // Feedback image
  output logic [SLOT_BITS-1:0] actual_slot_map, // Present modules, consecutive from 1
  output logic [SLOT_BITS-1:0] iso_timing_map, // Slots used for cycle timing
  output logic io_enable, // Station I/O active
  output logic nv_write, // Store map to retentive memory pulse
  output logic [SLOT_BITS-1:0] nv_map_out, // Map to retain
  output logic ds_ack, // Record request answered pulse
  output logic ds_reject, // Record request rejected
  output logic [15:0] ds_fault_code, // Fault code of answer
  output logic diag_no_module, // No module diagnostic
  output logic diag_wrong_module, // Incorrect module diagnostic
  output logic id_diag_overflow, // Highest identifier diagnostic bit
  output logic [7:0] diag_status1, // Diagnostic status byte 1
  output logic group_fault_indicator, // Station fault lamp
  output logic bus_fault_indicator // Bus fault lamp
);

  // Operating states of the station
  typedef enum logic [2:0] {
    S_UNCFG,
    S_WAIT_OPT,
    S_RUN,
    S_HOLD,
    S_REFUSED
  } state_type;

  // All state of the block
  typedef struct packed {
    state_type st;
    logic boot_done;
    logic [SLOT_BITS-1:0] ctrl_raw;
    logic [SLOT_BITS-1:0] applied;
    logic opt_valid;
    logic [SLOT_BITS-1:0] fb;
    logic [SLOT_BITS-1:0] actual;
    logic [SLOT_BITS-1:0] iso;
    logic [DATA_W-1:0] outs;
    logic [DATA_W-1:0] ins;
    logic nv_wr;
    logic ds_ack;
    logic ds_rej;
    logic [15:0] ds_code;
    logic no_mod;
    logic wrong_mod;
    logic ovf;
    logic refused;
  } ctl_type;

  ctl_type r; // Registered state
  ctl_type n; // Next state
  logic [COUNT_W-1:0] present_cnt; // Plugged slots 1..63
  logic [SLOT_BITS-1:0] consec_map; // Thermometer of present modules
  logic [SLOT_BITS-1:0] expected; // Slots that should hold a module
  logic miss_any; // Some expected slot is empty
  logic wrong_any; // Some expected slot has wrong or bad module
  logic match; // Actual arrangement equals configured one
  logic evaluate; // Start-up test requested this cycle

  // Count the plugged slots above the interface slot
  always_comb begin
    present_cnt = '0;
    for (int i = 1; i < SLOT_BITS; i++) begin
      present_cnt = present_cnt + COUNT_W'(slot_plugged[i]);
    end
  end

  // Consecutive slot numbers from 1 without gaps
  genvar g;
  generate
    for (g = 0; g < SLOT_BITS; g++) begin : g_consec
      assign consec_map[g] = (g != 0) && (COUNT_W'(g) <= present_cnt);
    end
  endgenerate

  // Next-state logic
  always_comb begin
    n = r;
    n.nv_wr = 1'b0;
    n.ds_ack = 1'b0;
    evaluate = 1'b0;
    // Capture retained option information once after reset release
    if (!r.boot_done) begin
      n.boot_done = 1'b1;
      n.opt_valid = nv_valid_in;
      n.applied = nv_map_in;
    end else if (ctrl_wr && (ctrl_image != r.ctrl_raw)) begin
      n.ctrl_raw = ctrl_image;
      if (ctrl_image[VALID_BIT]) begin
        n.applied = ctrl_image;
        n.opt_valid = 1'b1;
        n.nv_wr = 1'b1;
        evaluate = (r.st == S_WAIT_OPT);
      end
    end
    expected = n.applied & slot_configured;
    expected[VALID_BIT] = 1'b0;
    miss_any = |(expected & ~slot_plugged);
    wrong_any = |(expected & slot_plugged & ~slot_good);
    match = !miss_any && !wrong_any;
    // State sequencing
    case (r.st)
      S_UNCFG: begin
        if (cfg_accepted && r.boot_done) begin
          if (r.opt_valid) begin
            evaluate = 1'b1;
          end else begin
            n.st = S_WAIT_OPT;
          end
        end
      end
      S_WAIT_OPT: begin
        // Stays here until a valid control image arrives
        n.st = S_WAIT_OPT;
      end
      S_RUN: begin
        if (!match) begin
          n.st = S_HOLD;
        end
      end
      S_HOLD, S_REFUSED: begin
        // Re-enable once arrangement matches again
        if (match) begin
          n.st = S_RUN;
        end
      end
      default: begin
        n.st = S_UNCFG;
      end
    endcase
    // Start-up test of set against actual arrangement
    if (evaluate) begin
      if (match) begin
        n.st = S_RUN;
      end else if (!allow_mismatch) begin
        n.st = S_REFUSED;
      end else begin
        n.st = S_HOLD;
      end
    end
    n.refused = (n.st == S_REFUSED);
    n.no_mod = n.refused && miss_any;
    n.wrong_mod = n.refused && wrong_any;
    n.ovf = (plugged_count > MAX_REPORTED);
    n.actual = consec_map;
    n.iso = slot_configured;
    // Cyclic exchange of process data and feedback
    if (cycle_strobe) begin
      // other output bytes ignored while waiting
      n.outs = (n.st == S_RUN) ? output_process_image : '0;
      n.ins = (n.st == S_RUN) ? station_inputs : '0;
      n.fb = n.applied & slot_configured & slot_plugged & slot_good;
      // bit 0 shows option handling active
      n.fb[VALID_BIT] = n.opt_valid;
    end
    if (n.st != S_RUN) begin
      n.outs = '0;
    end
    // Data record request handling
    if (ds_req) begin
      n.ds_ack = 1'b1;
      n.ds_rej = (ds_slot != '0) && !(n.applied[ds_slot] && slot_configured[ds_slot]);
      n.ds_code = n.ds_rej ? FAULT_ABSENT_SLOT : FAULT_NONE;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      r.st <= S_UNCFG;
      r.boot_done <= 1'b0;
      r.ctrl_raw <= MAP_RESET;
      r.applied <= MAP_RESET;
      r.opt_valid <= 1'b0;
      r.fb <= MAP_RESET;
      r.actual <= MAP_RESET;
      r.iso <= MAP_RESET;
      r.outs <= '0;
      r.ins <= '0;
      r.nv_wr <= 1'b0;
      r.ds_ack <= 1'b0;
      r.ds_rej <= 1'b0;
      r.ds_code <= FAULT_NONE;
      r.no_mod <= 1'b0;
      r.wrong_mod <= 1'b0;
      r.ovf <= 1'b0;
      r.refused <= 1'b0;
    end else begin
      r <= n;
    end
  end

  // Output mapping
  assign station_outputs = r.outs;
  assign input_process_image = r.ins;
  assign slot_presence_feedback = r.fb;
  assign actual_slot_map = r.actual;
  assign iso_timing_map = r.iso;
  // I/O runs as soon as state is run
  assign io_enable = (r.st == S_RUN);
  assign nv_write = r.nv_wr;
  assign nv_map_out = r.applied;
  assign ds_ack = r.ds_ack;
  assign ds_reject = r.ds_rej;
  assign ds_fault_code = r.ds_code;
  assign diag_no_module = r.no_mod;
  assign diag_wrong_module = r.wrong_mod;
  assign id_diag_overflow = r.ovf;
  always_comb begin
    diag_status1 = STATUS1_RESET;
    diag_status1[STATUS1_EXT_BIT] = r.ovf;
  end
  assign group_fault_indicator = r.ovf || r.refused;
  assign bus_fault_indicator = r.refused;

endmodule // option_slot_presence_control

// ---- sim/slot_ctl_asserts.sv ----
`timescale 1ns/10ps
module slot_ctl_asserts
  import option_slot_pkg::*;
#(
  parameter int DATA_W = 32 // Process data width
) (
  input wire logic clk, // Clock
  input wire logic reset, // Reset
  input wire logic io_enable, // I/O on
  input wire logic [DATA_W-1:0] station_outputs, // To modules
  input wire logic ds_req, // Record request
  input wire logic ds_ack, // Record answered
  input wire logic ds_reject, // Record refused
  input wire logic [15:0] ds_fault_code, // Answer code
  input wire logic [COUNT_W-1:0] plugged_count, // Module count
  input wire logic id_diag_overflow, // Overflow bit
  input wire logic [7:0] diag_status1, // Status byte 1
  input wire logic group_fault_indicator, // Station lamp
  input wire logic bus_fault_indicator, // Bus lamp
  input wire logic ctrl_wr, // Control write
  input wire logic [SLOT_BITS-1:0] ctrl_image, // Control image
  input wire logic nv_write, // Store pulse
  input wire logic [SLOT_BITS-1:0] nv_map_out // Applied map
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  AST_IO_OFF: assert property (!io_enable |-> station_outputs == '0)
    else $error("Outputs driven while I/O off");
  AST_DS_ACK: assert property (ds_req |=> ds_ack)
    else $error("Record request not answered");
  AST_DS_CODE: assert property (ds_ack |-> ds_fault_code == (ds_reject ? FAULT_ABSENT_SLOT : FAULT_NONE))
    else $error("Record answer code wrong");
  AST_OVF: assert property (plugged_count > MAX_REPORTED |=> id_diag_overflow
    && diag_status1[STATUS1_EXT_BIT] && group_fault_indicator)
    else $error("Overflow not flagged");
  AST_NO_OVF: assert property (plugged_count <= MAX_REPORTED |=> !id_diag_overflow)
    else $error("Overflow flagged wrongly");
  AST_REFUSE: assert property (bus_fault_indicator |-> group_fault_indicator && !io_enable)
    else $error("Refused start with I/O on");
  AST_INVALID: assert property (ctrl_wr && !ctrl_image[VALID_BIT] |=> !nv_write)
    else $error("Invalid image applied");
  AST_LATCH: assert property (nv_write |-> $past(ctrl_wr) && nv_map_out == $past(ctrl_image))
    else $error("Applied map differs from write");
  // Main scenarios reached
  cover property ($rose(io_enable));
  cover property (ds_ack && ds_reject);
  cover property (bus_fault_indicator);
endmodule // slot_ctl_asserts

// ---- sim/slot_master_model.sv ----
`timescale 1ns/10ps
module slot_master_model
  import option_slot_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic go, // Start a map write
  input wire logic [SLOT_BITS-1:0] map, // Declared slots
  input wire logic [SLOT_BITS-1:0] fb, // Feedback image
  output logic ctrl_wr, // Control write
  output logic [SLOT_BITS-1:0] ctrl_image, // Control image
  output logic fb_ok // Feedback agrees
);
  logic step_r; // Validity write pending
  initial begin
    ctrl_wr = 1'b0;
    ctrl_image = '0;
    step_r = 1'b0;
  end
  always @(posedge clk) begin
    ctrl_wr <= go | step_r;
    step_r <= go;
    if (go) begin
      ctrl_image <= {map[SLOT_BITS-1:1], 1'b0};
    end
    if (step_r) begin
      ctrl_image[VALID_BIT] <= 1'b1;
    end
  end
  assign fb_ok = (fb == ctrl_image);
endmodule // slot_master_model

// ---- sim/tb_top.sv ----
`timescale 1ns/10ps
module tb_top
  import option_slot_pkg::*;
;
  `define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
    $display("Error at %0t: got %h exp %h", $time, a, b); end end
  localparam logic [63:0] P3 = 64'h0000_0000_0000_000E; // Slots 1 to 3
  logic clk = 0, reset = 1, cfg_accepted = 0, cycle_strobe = 0, ds_req = 0, allow_mismatch = 1, nv_valid_in = 0;
  logic go = 0, fb_ok, ctrl_wr, io_enable, nv_write, ds_ack, ds_reject, diag_no_module, diag_wrong_module;
  logic id_diag_overflow, group_fault_indicator, bus_fault_indicator;
  logic [5:0] ds_slot = 0;
  logic [7:0] plugged_count = 8'h03, diag_status1;
  logic [15:0] ds_fault_code;
  logic [31:0] output_process_image = 32'hA5A5_0001, station_inputs = 32'h5A5A_0002;
  logic [31:0] station_outputs, input_process_image;
  logic [63:0] slot_configured = 64'h0000_0000_0000_002E, slot_plugged = P3, slot_good = P3, map = P3;
  logic [63:0] nv_map_in = '0, ctrl_image, slot_presence_feedback, actual_slot_map, iso_timing_map, nv_map_out;
  int error_cnt = 0, cmp_count = 0;
  option_slot_presence_control #(.DATA_W(32)) i_dut (.clk, .reset, .cfg_accepted, .cycle_strobe, .ctrl_wr,
    .ctrl_image, .output_process_image, .station_inputs, .slot_configured, .slot_plugged, .slot_good,
    .plugged_count, .allow_mismatch, .nv_valid_in, .nv_map_in, .ds_req, .ds_slot, .station_outputs,
    .input_process_image, .slot_presence_feedback, .actual_slot_map, .iso_timing_map, .io_enable, .nv_write,
    .nv_map_out, .ds_ack, .ds_reject, .ds_fault_code, .diag_no_module, .diag_wrong_module, .id_diag_overflow,
    .diag_status1, .group_fault_indicator, .bus_fault_indicator);
  slot_master_model i_master (.clk, .go, .map, .fb(slot_presence_feedback), .ctrl_wr, .ctrl_image, .fb_ok);
  always #4 clk = ~clk;
  // Wait n rising edges
  task automatic e(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Reset, then configuration accepted
  task automatic boot();
    @(posedge clk) reset <= 1;
    e(5);
    reset <= 0;
    e(2);
    cfg_accepted <= 1;
    e(1);
    cfg_accepted <= 0;
    e(3);
    @(negedge clk);
  endtask
  // One exchange cycle
  task automatic strobe();
    @(posedge clk) cycle_strobe <= 1;
    @(posedge clk) cycle_strobe <= 0;
    @(negedge clk);
  endtask
  // Record request and answer check
  task automatic rec(input logic [5:0] s, input logic rj);
    @(posedge clk) begin
      ds_req <= 1;
      ds_slot <= s;
    end
    @(posedge clk) ds_req <= 0;
    @(negedge clk);
    `CHK({ds_ack, ds_reject, ds_fault_code}, {1'b1, rj, rj ? FAULT_ABSENT_SLOT : FAULT_NONE})
  endtask
  // Master map write, then settle
  task automatic put(input logic [63:0] m, input int n);
    @(posedge clk) begin
      map <= m;
      go <= 1;
    end
    @(posedge clk) go <= 0;
    e(n);
    @(negedge clk);
  endtask
  // Verdict and end of run
  task automatic results();
    if (error_cnt == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog
  initial begin
    #100000;
    error_cnt++;
    results();
  end
  initial begin
    boot();
    strobe();
    `CHK({io_enable, bus_fault_indicator, slot_presence_feedback[0]}, 3'b000)
    `CHK(station_outputs, 32'h0000_0000)
    `CHK(input_process_image, 32'h0000_0000)
    put(P3, 4);
    `CHK({io_enable, nv_map_out}, {1'b1, P3[63:1], 1'b1})
    strobe();
    `CHK({station_outputs, input_process_image}, {output_process_image, station_inputs})
    `CHK({fb_ok, slot_presence_feedback}, {1'b1, P3[63:1], 1'b1})
    rec(6'd5, 1'b1);
    rec(6'd2, 1'b0);
    rec(6'd0, 1'b0);
    put(P3 | 64'h0000_0100_0000_0000, 4);
    `CHK({io_enable, nv_map_out}, {1'b1, 64'h0000_0100_0000_000F})
    @(posedge clk) slot_good <= 64'h0000_0000_0000_000A;
    strobe();
    `CHK({io_enable, slot_presence_feedback}, {1'b0, 64'h0000_0000_0000_000B})
    @(posedge clk) slot_good <= P3;
    e(2);
    @(negedge clk);
    `CHK(io_enable, 1'b1)
    @(posedge clk) plugged_count <= 8'h40;
    e(2);
    @(negedge clk);
    `CHK({id_diag_overflow, diag_status1[STATUS1_EXT_BIT], group_fault_indicator}, 3'b111)
    @(posedge clk) plugged_count <= 8'h3F;
    e(2);
    @(negedge clk);
    `CHK(id_diag_overflow, 1'b0)
    `CHK(actual_slot_map, P3)
    `CHK(iso_timing_map, slot_configured)
    @(posedge clk) begin
      nv_valid_in <= 1;
      nv_map_in <= {P3[63:1], 1'b1};
    end
    boot();
    `CHK(io_enable, 1'b1)
    @(posedge clk) begin
      allow_mismatch <= 0;
      slot_plugged <= 64'h0000_0000_0000_0006;
    end
    boot();
    `CHK({io_enable, bus_fault_indicator, diag_no_module, diag_wrong_module}, 4'b0110)
    // Module back in place but with bad status: still refused, wrong module
    @(posedge clk) begin
      slot_plugged <= P3;
      slot_good <= 64'h0000_0000_0000_000A;
    end
    e(2);
    @(negedge clk);
    `CHK({io_enable, bus_fault_indicator, diag_no_module, diag_wrong_module}, 4'b0101)
    // Arrangement matches again: I/O back on, diagnostics gone
    @(posedge clk) slot_good <= P3;
    e(2);
    @(negedge clk);
    `CHK({io_enable, bus_fault_indicator, diag_no_module, diag_wrong_module}, 4'b1000)
    results();
  end
endmodule // tb_top
bind option_slot_presence_control slot_ctl_asserts #(.DATA_W(DATA_W)) i_chk (.clk, .reset, .io_enable,
  .station_outputs, .ds_req, .ds_ack, .ds_reject, .ds_fault_code, .plugged_count, .id_diag_overflow,
  .diag_status1, .group_fault_indicator, .bus_fault_indicator, .ctrl_wr, .ctrl_image, .nv_write, .nv_map_out);
